/* File: rtl/cfm_fault_monitor.sv */
// Purpose: Four fault conditions gathering caption and extended_program_data errors, with aux inputs
// Assumes: All inputs synchronous to core_clk; frame_tick is a one-cycle pulse per video frame
// Notes: Register port read data valid the cycle after reg_rd
//
// What this block does
// - A disabled condition never shows its alert on the display.
// - Hold time 0 to 990 frames in tens, or until reset by default.
// - Alert shows while its condition is active and enabled.
// - Held condition released by hold timer expiry, aux input, clear command or panel switch.
// - Each condition chooses blinking or steady alert.
// - Source: input video absent or wrong standard.
// - Source: caption waveform absent.
// - Sources: each of four caption channels and four text channels missing.
// - Source: caption byte parity failure.
// - Source: extended data packet checksum invalid.
// - Sources: duplicated control codes in field one, field two.
// - Sources: control code missing its duplicate in field one, field two.
// - Sources: invalid control code in field one, field two.
// - Source: incomplete control code pair in a frame.
// - Sources: invalid content of each of ten extended data items.
// - Sources: eight extended data items not seen within their priority timeout.
// - Clear command releases all held conditions; cancel changes nothing.
// - Each aux input selects high or low as active level.
// - Each aux input selects level or edge triggering.
// - Inputs one and two share a function, three and four another.
// - High, medium, low timeouts 1 to 900 seconds, default 1, 5, 45.
// - Default function: first of pair turns overlay off, second resets faults.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "cfm_map.svh"
`default_nettype none

module cfm_fault_monitor #(
  parameter int NCOND = 4,
  parameter int NAUX = 4,
  parameter int NSEEK = 8,
  parameter int NXDS = 10,
  parameter int CYC_PER_SEC = `CFM_SEC_NS / `CFM_CLK_PERIOD_NS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic frame_tick,
  input wire logic video_absent,
  input wire logic caption_wave_absent,
  input wire logic [3:0] caption_channel_missing,
  input wire logic [3:0] text_missing,
  input wire logic parity_err,
  input wire logic checksum_err,
  input wire logic [1:0] dup_code,
  input wire logic [1:0] nodup_code,
  input wire logic [1:0] invalid_code,
  input wire logic partial_pair,
  input wire logic [NXDS-1:0] extended_program_data_invalid,
  input wire logic [NSEEK-1:0] extended_program_data_seen,
  input wire logic panel_clear,
  input wire logic [NAUX-1:0] aux_input_line,
  output logic [NCOND-1:0] fault_show,
  output logic [NCOND-1:0] fault_blink,
  output logic onscreen_overlay_off,
  output logic [1:0] caption_channel_sel,
  output logic [1:0] text_sel
);

  localparam int SECW = $clog2(CYC_PER_SEC + 1);

  logic [`CFM_NSRC-1:0] src;
  logic [NSEEK-1:0] seek_miss;
  logic [NCOND-1:0] trig;
  logic [NCOND-1:0] trig_q_r;
  logic [NCOND-1:0] held_r;
  logic [NCOND-1:0] en_r;
  logic [NCOND-1:0] blink_r;
  logic [6:0] hold_r [NCOND];
  logic [`CFM_NSRC-1:0] mask_r [NCOND];
  logic [9:0] prio_r [3];
  logic [2*NSEEK-1:0] seek_prio_r;
  logic [NAUX-1:0] aux_lvl_r;
  logic [NAUX-1:0] aux_edge_r;
  cfm_pkg::cfm_aux_func_t func12_r;
  cfm_pkg::cfm_aux_func_t func34_r;
  logic [NAUX-1:0] aux_act;
  logic [NAUX-1:0] aux_act_q_r;
  logic [NAUX-1:0] aux_trig;
  logic ovl_tog_r;
  logic aux_clear;
  logic reg_clear;
  logic clear_all;
  logic [SECW-1:0] sec_cnt_r;
  logic sec_tick_r;

  // Error source vector, bit order fixed for the mask registers
  assign src = {seek_miss,
                extended_program_data_invalid,
                partial_pair,
                invalid_code,
                nodup_code,
                dup_code,
                checksum_err,
                parity_err,
                text_missing, caption_channel_missing,
                caption_wave_absent,
                video_absent};

  // Aux inputs: polarity then level or edge
  genvar a;
  for (a = 0; a < NAUX; a++) begin : g_aux
    assign aux_act[a] = aux_lvl_r[a] ? aux_input_line[a] : ~aux_input_line[a];
    assign aux_trig[a] = aux_edge_r[a] ? (aux_act[a] & ~aux_act_q_r[a]) : aux_act[a];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aux_act_q_r <= '0;
    end else begin
      aux_act_q_r <= aux_act;
    end
  end

  // Second input of each pair resets faults in the default function
  assign aux_clear = (func12_r == cfm_pkg::CFM_AUX_OVL_RESET && aux_trig[1])
                   | (func34_r == cfm_pkg::CFM_AUX_OVL_RESET && aux_trig[3]);
  assign reg_clear = reg_wr && reg_addr == `CFM_CLEAR_ADDR && reg_wdata[0];
  assign clear_all = aux_clear | reg_clear | panel_clear;

  // Overlay off: level mode follows the input, edge mode toggles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ovl_tog_r <= 1'b0;
      onscreen_overlay_off <= 1'b0;
    end else begin
      if ((func12_r == cfm_pkg::CFM_AUX_OVL_RESET && aux_edge_r[0] && aux_trig[0])
          ^ (func34_r == cfm_pkg::CFM_AUX_OVL_RESET && aux_edge_r[2] && aux_trig[2])) begin
        ovl_tog_r <= ~ovl_tog_r;
      end
      onscreen_overlay_off <= ovl_tog_r
        | (func12_r == cfm_pkg::CFM_AUX_OVL_RESET && !aux_edge_r[0] && aux_trig[0])
        | (func34_r == cfm_pkg::CFM_AUX_OVL_RESET && !aux_edge_r[2] && aux_trig[2]);
    end
  end

  // Select function: pair encodes the channel, first input is the high bit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      caption_channel_sel <= 2'h0;
      text_sel <= 2'h0;
    end else begin
      if (func12_r == cfm_pkg::CFM_AUX_SELECT) begin
        caption_channel_sel <= {aux_act[0], aux_act[1]};
      end
      if (func34_r == cfm_pkg::CFM_AUX_SELECT) begin
        text_sel <= {aux_act[2], aux_act[3]};
      end
    end
  end

  // One-second enable for the seek timeouts
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sec_cnt_r <= '0;
      sec_tick_r <= 1'b0;
    end else begin
      sec_tick_r <= 1'b0;
      if (sec_cnt_r == SECW'(CYC_PER_SEC - 1)) begin
        sec_cnt_r <= '0;
        sec_tick_r <= 1'b1;
      end else begin
        sec_cnt_r <= sec_cnt_r + SECW'(1);
      end
    end
  end

  // Seek timers count whole seconds: a flag may come a second late, never early
  genvar s;
  for (s = 0; s < NSEEK; s++) begin : g_seek
    logic [9:0] cnt_r;
    logic [9:0] limit;
    logic [1:0] psel;
    assign psel = seek_prio_r[2*s +: 2];
    // Unused code 3 falls back to the low priority timeout
    assign limit = (psel == 2'(cfm_pkg::CFM_PRIO_HIGH)) ? prio_r[0] :
                   (psel == 2'(cfm_pkg::CFM_PRIO_MED)) ? prio_r[1] : prio_r[2];
    always_ff @(posedge core_clk) begin
      if (rst) begin
        cnt_r <= 10'h000;
      end else if (extended_program_data_seen[s]) begin
        cnt_r <= 10'h000;
      end else if (sec_tick_r && cnt_r <= limit) begin
        cnt_r <= cnt_r + 10'h001;
      end
    end
    assign seek_miss[s] = (cnt_r > limit) && !extended_program_data_seen[s];
  end

  // Fault conditions
  genvar k;
  for (k = 0; k < NCOND; k++) begin : g_fc
    localparam logic [7:0] BASE = 8'(k * 16);
    logic [9:0] hcnt_r;
    logic [9:0] target;
    logic until_reset;
    logic wr_ctrl;
    logic wr_lo;
    logic wr_hi;

    assign wr_ctrl = reg_wr && reg_addr == BASE + `CFM_FC_CTRL_OFS;
    assign wr_lo = reg_wr && reg_addr == BASE + `CFM_FC_MASK_LO_OFS;
    assign wr_hi = reg_wr && reg_addr == BASE + `CFM_FC_MASK_HI_OFS;
    assign trig[k] = |(mask_r[k] & src);
    // Codes above the largest step also mean hold until reset
    assign until_reset = hold_r[k] > `CFM_HOLD_MAX_CODE;
    assign target = 10'({3'h0, hold_r[k]}) * `CFM_HOLD_STEP;

    always_ff @(posedge core_clk) begin
      if (rst) begin
        en_r[k] <= 1'b0;
        blink_r[k] <= 1'b0;
        hold_r[k] <= `CFM_HOLD_UNTIL_RESET;
      end else if (wr_ctrl) begin
        en_r[k] <= reg_wdata[`CFM_CTRL_EN_BIT];
        blink_r[k] <= reg_wdata[`CFM_CTRL_BLINK_BIT];
        hold_r[k] <= reg_wdata[`CFM_CTRL_HOLD_MSB:`CFM_CTRL_HOLD_LSB];
      end
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        mask_r[k] <= '0;
      end else if (wr_lo) begin
        mask_r[k][31:0] <= reg_wdata;
      end else if (wr_hi) begin
        mask_r[k][`CFM_NSRC-1:32] <= reg_wdata[`CFM_MASK_HI_W-1:0];
      end
    end

    // Hold counter saturates at the top step so it never wraps
    always_ff @(posedge core_clk) begin
      if (rst) begin
        hcnt_r <= 10'h000;
      end else if (trig[k] && !trig_q_r[k]) begin
        hcnt_r <= 10'h000;
      end else if (frame_tick && hcnt_r < `CFM_HOLD_STEP * 10'({3'h0, `CFM_HOLD_MAX_CODE})) begin
        hcnt_r <= hcnt_r + 10'h001;
      end
    end

    // A live trigger beats any clear in the same cycle
    always_ff @(posedge core_clk) begin
      if (rst) begin
        held_r[k] <= 1'b0;
        trig_q_r[k] <= 1'b0;
      end else begin
        trig_q_r[k] <= trig[k];
        if (trig[k]) begin
          held_r[k] <= 1'b1;
        end else if (clear_all) begin
          held_r[k] <= 1'b0;
        end else if (!until_reset && hcnt_r >= target) begin
          held_r[k] <= 1'b0;
        end
      end
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        fault_show[k] <= 1'b0;
        fault_blink[k] <= 1'b0;
      end else begin
        fault_show[k] <= en_r[k] & (trig[k] | held_r[k]);
        fault_blink[k] <= en_r[k] & blink_r[k];
      end
    end
  end

  // Priority timeouts, writes clamped into 1 to 900 seconds
  genvar p;
  for (p = 0; p < 3; p++) begin : g_prio
    localparam logic [7:0] PADDR = `CFM_PRIO_HIGH_ADDR + 8'(p * 4);
    localparam logic [9:0] PRST = (p == 0) ? `CFM_PRIO_HIGH_RST :
                                  (p == 1) ? `CFM_PRIO_MED_RST : `CFM_PRIO_LOW_RST;
    always_ff @(posedge core_clk) begin
      if (rst) begin
        prio_r[p] <= PRST;
      end else if (reg_wr && reg_addr == PADDR) begin
        if (reg_wdata[9:0] < `CFM_PRIO_MIN || reg_wdata[31:10] != 22'h000000) begin
          prio_r[p] <= (reg_wdata[31:10] != 22'h000000) ? `CFM_PRIO_MAX : `CFM_PRIO_MIN;
        end else if (reg_wdata[9:0] > `CFM_PRIO_MAX) begin
          prio_r[p] <= `CFM_PRIO_MAX;
        end else begin
          prio_r[p] <= reg_wdata[9:0];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      seek_prio_r <= '0;
    end else if (reg_wr && reg_addr == `CFM_SEEK_PRIO_ADDR) begin
      seek_prio_r <= reg_wdata[2*NSEEK-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aux_lvl_r <= `CFM_AUX_LVL_RST;
      aux_edge_r <= `CFM_AUX_EDGE_RST;
      func12_r <= cfm_pkg::CFM_AUX_OVL_RESET;
      func34_r <= cfm_pkg::CFM_AUX_OVL_RESET;
    end else if (reg_wr && reg_addr == `CFM_AUX_CFG_ADDR) begin
      aux_lvl_r <= reg_wdata[`CFM_AUX_LVL_LSB +: NAUX];
      aux_edge_r <= reg_wdata[`CFM_AUX_EDGE_LSB +: NAUX];
      func12_r <= cfm_pkg::cfm_aux_func_t'(reg_wdata[`CFM_AUX_F12_LSB +: 2]);
      func34_r <= cfm_pkg::cfm_aux_func_t'(reg_wdata[`CFM_AUX_F34_LSB +: 2]);
    end
  end

  // Read mux; unmapped and write-only addresses read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= 32'h00000000;
      for (int i = 0; i < NCOND; i++) begin
        if (reg_addr == 8'(i * 16) + `CFM_FC_CTRL_OFS) begin
          reg_rdata[`CFM_CTRL_EN_BIT] <= en_r[i];
          reg_rdata[`CFM_CTRL_BLINK_BIT] <= blink_r[i];
          reg_rdata[`CFM_CTRL_HOLD_MSB:`CFM_CTRL_HOLD_LSB] <= hold_r[i];
        end
        if (reg_addr == 8'(i * 16) + `CFM_FC_MASK_LO_OFS) begin
          reg_rdata <= mask_r[i][31:0];
        end
        if (reg_addr == 8'(i * 16) + `CFM_FC_MASK_HI_OFS) begin
          reg_rdata[`CFM_MASK_HI_W-1:0] <= mask_r[i][`CFM_NSRC-1:32];
        end
      end
      if (reg_addr == `CFM_PRIO_HIGH_ADDR) begin
        reg_rdata[9:0] <= prio_r[0];
      end
      if (reg_addr == `CFM_PRIO_MED_ADDR) begin
        reg_rdata[9:0] <= prio_r[1];
      end
      if (reg_addr == `CFM_PRIO_LOW_ADDR) begin
        reg_rdata[9:0] <= prio_r[2];
      end
      if (reg_addr == `CFM_SEEK_PRIO_ADDR) begin
        reg_rdata[2*NSEEK-1:0] <= seek_prio_r;
      end
      if (reg_addr == `CFM_AUX_CFG_ADDR) begin
        reg_rdata[`CFM_AUX_LVL_LSB +: NAUX] <= aux_lvl_r;
        reg_rdata[`CFM_AUX_EDGE_LSB +: NAUX] <= aux_edge_r;
        reg_rdata[`CFM_AUX_F12_LSB +: 2] <= func12_r;
        reg_rdata[`CFM_AUX_F34_LSB +: 2] <= func34_r;
      end
      if (reg_addr == `CFM_STATUS_ADDR) begin
        reg_rdata[NCOND-1:0] <= trig;
        reg_rdata[8 +: NCOND] <= held_r;
        reg_rdata[16 +: NAUX] <= aux_act;
        reg_rdata[24] <= onscreen_overlay_off;
      end
      if (reg_addr == `CFM_SEEK_STAT_ADDR) begin
        reg_rdata[NSEEK-1:0] <= seek_miss;
      end
    end
  end

endmodule : cfm_fault_monitor

`default_nettype wire

/* File: rtl/cfm_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the caption fault monitor
// Assumes: Byte addresses on a 32-bit register port, one word per register
// Notes: Included by bare name
`ifndef CFM_MAP_SVH
`define CFM_MAP_SVH

// Per fault condition registers, condition k at base k * stride
`define CFM_FC_STRIDE 8'h10
`define CFM_FC_CTRL_OFS 8'h00
`define CFM_FC_MASK_LO_OFS 8'h04
`define CFM_FC_MASK_HI_OFS 8'h08
`define CFM_PRIO_HIGH_ADDR 8'h40
`define CFM_PRIO_MED_ADDR 8'h44
`define CFM_PRIO_LOW_ADDR 8'h48
`define CFM_SEEK_PRIO_ADDR 8'h4C
`define CFM_AUX_CFG_ADDR 8'h50
`define CFM_CLEAR_ADDR 8'h54
`define CFM_STATUS_ADDR 8'h58
`define CFM_SEEK_STAT_ADDR 8'h5C

// Fault condition control fields
`define CFM_CTRL_EN_BIT 0
`define CFM_CTRL_BLINK_BIT 1
`define CFM_CTRL_HOLD_LSB 8
`define CFM_CTRL_HOLD_MSB 14
`define CFM_HOLD_UNTIL_RESET 7'h7F
`define CFM_HOLD_MAX_CODE 7'h63
`define CFM_HOLD_STEP 10'h00A

// Error source count and mask split
`define CFM_NSRC 37
`define CFM_MASK_HI_W 5

// Aux input configuration fields
`define CFM_AUX_LVL_LSB 0
`define CFM_AUX_EDGE_LSB 4
`define CFM_AUX_F12_LSB 8
`define CFM_AUX_F34_LSB 10
`define CFM_AUX_LVL_RST 4'hF
`define CFM_AUX_EDGE_RST 4'h0

// Priority timeouts in seconds
`define CFM_PRIO_MIN 10'h001
`define CFM_PRIO_MAX 10'h384
`define CFM_PRIO_HIGH_RST 10'h001
`define CFM_PRIO_MED_RST 10'h005
`define CFM_PRIO_LOW_RST 10'h02D

// Second tick derived from the clock
`define CFM_SEC_NS 1000000000
`define CFM_CLK_PERIOD_NS 4

`endif

/* File: rtl/cfm_pkg.sv */
// Purpose: Types shared by the caption fault monitor
// Assumes: Nothing beyond the map header
// Notes: Used by explicit package scope only
package cfm_pkg;

  typedef enum logic [1:0] {
    CFM_AUX_OFF,
    CFM_AUX_OVL_RESET,
    CFM_AUX_SELECT
  } cfm_aux_func_t;

  typedef enum logic [1:0] {
    CFM_PRIO_HIGH,
    CFM_PRIO_MED,
    CFM_PRIO_LOW
  } cfm_prio_t;

endpackage : cfm_pkg

/* File: verif/cfm_fault_monitor_monitor.sv */
// Purpose: Port-level checks of the caption fault monitor
// Assumes: Clear and show-cause checks are void once any seek source is masked
// Notes: Bound to every instance of the design
`timescale 1ns/1ps
`include "cfm_map.svh"
`default_nettype none
module cfm_fault_monitor_chk #(
  parameter int NCOND = 4,
  parameter int NAUX = 4,
  parameter int NXDS = 10
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic video_absent,
  input wire logic caption_wave_absent,
  input wire logic [3:0] caption_channel_missing,
  input wire logic [3:0] text_missing,
  input wire logic parity_err,
  input wire logic checksum_err,
  input wire logic [1:0] dup_code,
  input wire logic [1:0] nodup_code,
  input wire logic [1:0] invalid_code,
  input wire logic partial_pair,
  input wire logic [NXDS-1:0] extended_program_data_invalid,
  input wire logic panel_clear,
  input wire logic [NAUX-1:0] aux_input_line,
  input wire logic [NCOND-1:0] fault_show,
  input wire logic [NCOND-1:0] fault_blink,
  input wire logic onscreen_overlay_off,
  input wire logic [1:0] caption_channel_sel,
  input wire logic [1:0] text_sel
);
  logic any_src;
  logic clr_req;
  logic seek_armed_r;
  logic [NAUX-1:0] aux_prev_r;
  logic [2:0] wr_hist_r;
  logic [1:0] chg_hist_r;
  assign any_src = video_absent | caption_wave_absent | (|caption_channel_missing) | (|text_missing) | parity_err
    | checksum_err | (|dup_code) | (|nodup_code) | (|invalid_code) | partial_pair | (|extended_program_data_invalid);
  assign clr_req = panel_clear | (reg_wr & (reg_addr == `CFM_CLEAR_ADDR) & reg_wdata[0]);
  // Seek flags come from internal timers, invisible here
  always_ff @(posedge core_clk) begin
    if (rst) begin
      seek_armed_r <= 1'b0;
    end else if (reg_wr && reg_addr < 8'h40 && ((reg_addr[3:0] == 4'h4 && |reg_wdata[31:29])
        || (reg_addr[3:0] == 4'h8 && |reg_wdata[4:0]))) begin
      seek_armed_r <= 1'b1;
    end
  end
  // Reset counts as a cause, so no reset is needed on the history
  always_ff @(posedge core_clk) begin
    aux_prev_r <= aux_input_line;
    wr_hist_r <= {wr_hist_r[1:0], reg_wr | rst};
    chg_hist_r <= {chg_hist_r[0], rst | (aux_input_line != aux_prev_r)};
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property ($fell(rst) |-> fault_show == '0 && !onscreen_overlay_off)
    else $error("outputs not quiet after reset");
  a_clear_release: assert property (clr_req && !any_src && !seek_armed_r |-> ##2 fault_show == '0)
    else $error("alert still shown after clear");
  a_show_cause: assert property ((fault_show & ~$past(fault_show)) != '0 && !seek_armed_r
    |-> $past(any_src) || $past(reg_wr) || $past(reg_wr, 2)) else $error("alert rose without cause");
  a_blink_cfg: assert property ($changed(fault_blink) |-> |wr_hist_r)
    else $error("blink changed without a write");
  a_rdata_hold: assert property ($changed(reg_rdata) |-> $past(reg_rd))
    else $error("read data changed without a read");
  a_overlay_cause: assert property ($changed(onscreen_overlay_off) |-> |chg_hist_r || |wr_hist_r)
    else $error("overlay changed without aux cause");
  a_ccsel_cause: assert property ($changed(caption_channel_sel) |-> chg_hist_r[0] || |wr_hist_r)
    else $error("caption select changed without cause");
  a_txtsel_cause: assert property ($changed(text_sel) |-> chg_hist_r[0] || |wr_hist_r)
    else $error("text select changed without cause");
  c_show_blink: cover property (fault_show[1] && fault_blink[1]);
  c_timer_release: cover property ($fell(fault_show[1]) && !clr_req);
  c_overlay_off: cover property ($rose(onscreen_overlay_off));
endmodule : cfm_fault_monitor_chk
bind cfm_fault_monitor cfm_fault_monitor_chk #(.NCOND(NCOND), .NAUX(NAUX), .NXDS(NXDS)) u_chk (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .video_absent(video_absent), .caption_wave_absent(caption_wave_absent),
  .caption_channel_missing(caption_channel_missing), .text_missing(text_missing), .parity_err(parity_err),
  .checksum_err(checksum_err), .dup_code(dup_code), .nodup_code(nodup_code), .invalid_code(invalid_code),
  .partial_pair(partial_pair), .extended_program_data_invalid(extended_program_data_invalid),
  .panel_clear(panel_clear), .aux_input_line(aux_input_line), .fault_show(fault_show), .fault_blink(fault_blink),
  .onscreen_overlay_off(onscreen_overlay_off), .caption_channel_sel(caption_channel_sel), .text_sel(text_sel));
`default_nettype wire

/* File: verif/cfm_src_model.sv */
// Purpose: Caption decoder stand-in feeding error sources, frame pulses and item sightings
// Assumes: Bench sets the error pattern at clock edges
// Notes: Sightings every fourth cycle for each enabled item
`timescale 1ns/1ps
`default_nettype none
module cfm_src_model #(
  parameter int FDIV = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [28:0] src_vec,
  input wire logic [7:0] seen_en,
  output logic frame_tick,
  output logic video_absent,
  output logic caption_wave_absent,
  output logic [3:0] caption_channel_missing,
  output logic [3:0] text_missing,
  output logic parity_err,
  output logic checksum_err,
  output logic [1:0] dup_code,
  output logic [1:0] nodup_code,
  output logic [1:0] invalid_code,
  output logic partial_pair,
  output logic [9:0] extended_program_data_invalid,
  output logic [7:0] extended_program_data_seen
);
  logic [7:0] frame_cnt_r;
  logic [1:0] seen_cnt_r;
  always_ff @(posedge core_clk) begin
    if (rst || frame_tick) begin
      frame_cnt_r <= 8'h00;
    end else begin
      frame_cnt_r <= frame_cnt_r + 8'h01;
    end
  end
  always_ff @(posedge core_clk) begin
    seen_cnt_r <= rst ? 2'h0 : seen_cnt_r + 2'h1;
  end
  assign frame_tick = frame_cnt_r == 8'(FDIV - 1);
  assign extended_program_data_seen = (seen_cnt_r == 2'h0) ? seen_en : 8'h00;
  // Source bit order as the mask expects
  assign {extended_program_data_invalid, partial_pair, invalid_code, nodup_code, dup_code, checksum_err,
    parity_err, text_missing, caption_channel_missing, caption_wave_absent, video_absent} = src_vec;
endmodule : cfm_src_model
`default_nettype wire

/* File: verif/cfm_fault_monitor_tb_top.sv */
// Purpose: Directed register and source sequences for the caption fault monitor
// Assumes: One frame every 8 cycles, one second is 10 cycles
// Notes: Waits are the fixed latencies of the design
`timescale 1ns/1ps
`include "cfm_map.svh"
`default_nettype none
module cfm_fault_monitor_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic panel_clear = 1'b0;
  logic [3:0] aux_input_line = 4'h0;
  logic [28:0] src_vec = 29'h0;
  logic [7:0] seen_en = 8'hFF;
  logic [31:0] reg_rdata;
  logic frame_tick, video_absent, caption_wave_absent, parity_err, checksum_err, partial_pair;
  logic [3:0] caption_channel_missing, text_missing, fault_show, fault_blink;
  logic [1:0] dup_code, nodup_code, invalid_code, caption_channel_sel, text_sel;
  logic [9:0] extended_program_data_invalid;
  logic [7:0] extended_program_data_seen;
  logic onscreen_overlay_off;
  int miscompares = 0;
  int n_checks = 0;
  always #2 core_clk = ~core_clk;
  cfm_src_model #(.FDIV(8)) u_src (.core_clk(core_clk), .rst(rst), .src_vec(src_vec), .seen_en(seen_en),
    .frame_tick(frame_tick), .video_absent(video_absent), .caption_wave_absent(caption_wave_absent),
    .caption_channel_missing(caption_channel_missing), .text_missing(text_missing), .parity_err(parity_err),
    .checksum_err(checksum_err), .dup_code(dup_code), .nodup_code(nodup_code), .invalid_code(invalid_code),
    .partial_pair(partial_pair), .extended_program_data_invalid(extended_program_data_invalid),
    .extended_program_data_seen(extended_program_data_seen));
  cfm_fault_monitor #(.CYC_PER_SEC(10)) dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_tick(frame_tick),
    .video_absent(video_absent), .caption_wave_absent(caption_wave_absent),
    .caption_channel_missing(caption_channel_missing), .text_missing(text_missing), .parity_err(parity_err),
    .checksum_err(checksum_err), .dup_code(dup_code), .nodup_code(nodup_code), .invalid_code(invalid_code),
    .partial_pair(partial_pair), .extended_program_data_invalid(extended_program_data_invalid),
    .extended_program_data_seen(extended_program_data_seen), .panel_clear(panel_clear),
    .aux_input_line(aux_input_line), .fault_show(fault_show), .fault_blink(fault_blink),
    .onscreen_overlay_off(onscreen_overlay_off), .caption_channel_sel(caption_channel_sel), .text_sel(text_sel));
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    chk($sformatf("reg %h", a), reg_rdata, exp);
  endtask : rchk
  // One-cycle source pulse, sampled when the alert is due
  task automatic pulse(input int b);
    @(posedge core_clk);
    src_vec <= 29'h1 << b;
    @(posedge core_clk);
    src_vec <= 29'h0;
    cyc(1);
  endtask : pulse
  task automatic show(input logic [3:0] exp);
    chk("fault_show", {28'h0, fault_show}, {28'h0, exp});
  endtask : show
  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  initial begin
    cyc(5);
    rst <= 1'b0;
    rchk(8'h00, 32'h7F00);
    rchk(8'h40, 32'h1);
    rchk(8'h44, 32'h5);
    rchk(8'h48, 32'h2D);
    rchk(8'h50, 32'h50F);
    rchk(8'h54, 32'h0);
    rchk(8'h60, 32'h0);
    wr(8'h40, 32'h0);
    rchk(8'h40, 32'h1);
    wr(8'h40, 32'h3FF);
    rchk(8'h40, 32'h384);
    wr(8'h40, 32'h1);
    for (int i = 0; i < 29; i++) begin
      wr(8'(16 * (i % 4)), 32'h7F01);
      wr(8'(16 * (i % 4) + 4), 32'h1 << i);
      pulse(i);
      show(4'h1 << (i % 4));
      cyc(3);
      show(4'h1 << (i % 4));
      wr(`CFM_CLEAR_ADDR, 32'h0);
      cyc(2);
      show(4'h1 << (i % 4));
      wr(`CFM_CLEAR_ADDR, 32'h1);
      cyc(2);
      show(4'h0);
    end
    wr(8'h10, 32'h7F00);
    wr(8'h14, 32'h1);
    pulse(0);
    show(4'h0);
    rchk(`CFM_STATUS_ADDR, 32'h200);
    wr(8'h10, 32'h7F03);
    cyc(2);
    show(4'h2);
    chk("fault_blink", {28'h0, fault_blink}, 32'h2);
    wr(8'h10, 32'h7F01);
    cyc(2);
    chk("fault_blink", {28'h0, fault_blink}, 32'h0);
    @(posedge core_clk);
    panel_clear <= 1'b1;
    @(posedge core_clk);
    panel_clear <= 1'b0;
    cyc(2);
    show(4'h0);
    wr(8'h10, 32'h0201);
    pulse(0);
    cyc(100);
    pulse(0);
    cyc(100);
    show(4'h2);
    cyc(80);
    show(4'h0);
    pulse(28);
    show(4'h1);
    @(posedge core_clk);
    aux_input_line <= 4'h2;
    @(posedge core_clk);
    aux_input_line <= 4'h1;
    cyc(2);
    show(4'h0);
    chk("overlay", {31'h0, onscreen_overlay_off}, 32'h1);
    wr(`CFM_AUX_CFG_ADDR, 32'h50E);
    cyc(3);
    chk("overlay", {31'h0, onscreen_overlay_off}, 32'h0);
    @(posedge core_clk);
    aux_input_line <= 4'h0;
    wr(`CFM_AUX_CFG_ADDR, 32'h51F);
    cyc(1);
    aux_input_line <= 4'h1;
    cyc(4);
    chk("overlay", {31'h0, onscreen_overlay_off}, 32'h1);
    aux_input_line <= 4'h0;
    cyc(3);
    chk("overlay", {31'h0, onscreen_overlay_off}, 32'h1);
    aux_input_line <= 4'h1;
    cyc(3);
    chk("overlay", {31'h0, onscreen_overlay_off}, 32'h0);
    wr(`CFM_AUX_CFG_ADDR, 32'hA0F);
    aux_input_line <= 4'h6;
    cyc(3);
    chk("select", {28'h0, caption_channel_sel, text_sel}, 32'h6);
    aux_input_line <= 4'h9;
    cyc(3);
    chk("select", {28'h0, caption_channel_sel, text_sel}, 32'h9);
    wr(`CFM_SEEK_PRIO_ADDR, 32'h8);
    seen_en <= 8'hFC;
    cyc(100);
    rchk(`CFM_SEEK_STAT_ADDR, 32'h1);
    cyc(400);
    rchk(`CFM_SEEK_STAT_ADDR, 32'h3);
    wr(8'h34, 32'h2000_0000);
    cyc(3);
    show(4'h8);
    results();
  end
endmodule : cfm_fault_monitor_tb_top
`default_nettype wire
